// ### verilog/sad_pkg.sv
// Notes on behaviour
// - Five-bit channel code picks one of four pins
// - Selected pin forced to analog, port writes ignored
// - Port read of used pin: direction ? latch : 0
// - Full scale reads ff, bottom reads 00
// - One conversion lasts sixteen converter clocks
// - Control write starts conversion on next converter clock
// - Continuous mode overwrites result every conversion
// - Single mode converts once; clearing continuous stops
// - Done flag set per conversion, cleared by read
// - Interrupt enabled: done flag stays zero
// - Interrupt raised per conversion, cleared by access
// - All-ones channel code powers off; reset value
// - Codes select upper or lower reference; rest unknown
// - Wait mode leaves conversion and interrupt running
// - Stop mode aborts; conversion resumes afterwards
// - Eight-bit read-only result, refreshed on completion
// - Converter clock is bus clock divided by prescaler
package sad_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SCR_ADDR   = 8'h3c;
    localparam logic [7:0] RES_ADDR   = 8'h3e;
    localparam logic [7:0] CLK_ADDR   = 8'h3f;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int         FLAG_BIT   = 7;
    localparam int         IEN_BIT    = 6;
    localparam int         CONT_BIT   = 5;
    localparam int         DIV_LSB    = 5;

    // ------------------------------------------------------------
    // Channel codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CH_OFF     = 5'h1f;
    localparam logic [4:0] CH_VDDA    = 5'h1d;
    localparam logic [4:0] CH_VSSA    = 5'h1e;
    localparam logic [4:0] CH_RSVD    = 5'h1b;
    localparam logic [4:0] CH_RESET   = 5'h1f;
    localparam logic [2:0] DIV_RESET  = 3'h0;
    localparam logic [7:0] RES_RESET  = 8'h00;

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    localparam logic [3:0] CNT_LAST   = 4'hf;
    localparam logic [3:0] TRIALS     = 4'h8;
    localparam logic [7:0] SAR_FIRST  = 8'h80;
    localparam logic [3:0] DIV_MAXLIM = 4'hf;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sad_state_t;

endpackage : sad_pkg

// ### verilog/sad_prescaler.sv
`timescale 1ns/1ps
module sad_prescaler
    import sad_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Divide select
    input  wire logic [2:0] div_i,
    // Converter clock enable pulse
    output logic            tick_o
);

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } sad_pre_t;

    sad_pre_t   q_r;
    sad_pre_t   q_nxt;
    logic [3:0] lim;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        // 1xx collapses to the largest ratio
        lim = div_i[2] ? DIV_MAXLIM : 4'((4'h1 << div_i[1:0]) - 4'h1);
        q_nxt.tick = (q_r.cnt >= lim);
        q_nxt.cnt  = q_nxt.tick ? 4'h0 : q_r.cnt + 4'h1;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick_o = q_r.tick;

endmodule : sad_prescaler

// ### verilog/sad_pin_mux.sv
`timescale 1ns/1ps
module sad_pin_mux
    import sad_pkg::*;
#(
    parameter int NUM_PINS = 4
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // Channel code
    input  wire logic [4:0]          ch_i,
    // Port logic
    input  wire logic [NUM_PINS-1:0] port_data_i,
    input  wire logic [NUM_PINS-1:0] port_dir_i,
    output logic [NUM_PINS-1:0]      port_read_o,
    // Pads
    input  wire logic [NUM_PINS-1:0] pad_in_i,
    output logic [NUM_PINS-1:0]      pad_out_o,
    output logic [NUM_PINS-1:0]      pad_oe_n_o,
    output logic [NUM_PINS-1:0]      analog_en_o
);

    if (NUM_PINS != 4) begin : g_chk
        $error("Channel code maps exactly four pins");
    end

    typedef struct packed {
        logic [NUM_PINS-1:0] s1;
        logic [NUM_PINS-1:0] s2;
        logic [NUM_PINS-1:0] s3;
        logic [NUM_PINS-1:0] lvl;
        logic [NUM_PINS-1:0] rd;
        logic [NUM_PINS-1:0] dout;
        logic [NUM_PINS-1:0] oe_n;
        logic [NUM_PINS-1:0] ana;
    } sad_pin_t;

    sad_pin_t q_r;
    sad_pin_t q_nxt;

    // ------------------------------------------------------------
    // Per-pin override
    // ------------------------------------------------------------
    always_comb begin
        q_nxt    = q_r;
        q_nxt.s1 = pad_in_i;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        for (int i = 0; i < NUM_PINS; i++) begin
            // Filter: level moves only once two stages agree
            if (q_r.s2[i] == q_r.s3[i]) begin
                q_nxt.lvl[i] = q_r.s3[i];
            end
            q_nxt.ana[i]  = (ch_i[4:2] == 3'h0) && (ch_i[1:0] == 2'(i));
            q_nxt.dout[i] = port_data_i[i];
            q_nxt.oe_n[i] = !(port_dir_i[i] && !q_nxt.ana[i]);
            if (q_nxt.ana[i]) begin
                q_nxt.rd[i] = port_dir_i[i] & port_data_i[i];
            end else begin
                q_nxt.rd[i] = port_dir_i[i] ? port_data_i[i] : q_r.lvl[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q_r <= '{oe_n: '1, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign port_read_o = q_r.rd;
    assign pad_out_o   = q_r.dout;
    assign pad_oe_n_o  = q_r.oe_n;
    assign analog_en_o = q_r.ana;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sel_released;
        @(posedge clk_i) disable iff (reset_i)
        (ch_i == 5'h0) |=> (pad_oe_n_o[0] && analog_en_o[0]);
    endproperty
    a_sel_released : assert property (p_sel_released)
        else $error("Selected pin still driven by port");

endmodule : sad_pin_mux

// ### verilog/sad_sequencer.sv
`timescale 1ns/1ps
module sad_sequencer
    import sad_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RESET_I,
    // Register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic [7:0]      RDATA_O,
    // System modes
    input  wire logic       STOP_I,
    // Analog core
    input  wire logic       CMP_HIGH_I,
    output logic [7:0]      DAC_CODE_O,
    output logic [4:0]      MUX_SEL_O,
    output logic            CONV_PWR_O,
    output logic            CONV_BUSY_O,
    output logic            IRQ_O,
    // Shared port pins
    input  wire logic [3:0] PORT_DATA_I,
    input  wire logic [3:0] PORT_DIR_I,
    output logic [3:0]      PORT_READ_O,
    input  wire logic [3:0] PAD_IN_I,
    output logic [3:0]      PAD_OUT_O,
    output logic [3:0]      PAD_OE_N_O,
    output logic [3:0]      ANALOG_EN_O
);

    typedef struct packed {
        sad_state_t state;
        logic [3:0] cnt;
        logic [7:0] sar;
        logic [7:0] result;
        logic       pend;
        logic       flag;
        logic       irq;
        logic       ien;
        logic       cont;
        logic [4:0] ch;
        logic [2:0] div;
        logic       pwr;
        logic [7:0] rdata;
    } sad_seq_t;

    sad_seq_t   q_r;
    sad_seq_t   q_nxt;
    logic       tick;
    logic       scr_wr;
    logic       clk_wr;
    logic       res_rd;
    logic       start;
    logic       done;
    logic [2:0] idx;

    // ------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------
    sad_prescaler i_sad_prescaler (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .div_i   (q_r.div),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------
    // Pin override
    // ------------------------------------------------------------
    sad_pin_mux #(
        .NUM_PINS (4)
    ) i_sad_pin_mux (
        .clk_i       (CLK_I),
        .reset_i     (RESET_I),
        .ch_i        (q_r.ch),
        .port_data_i (PORT_DATA_I),
        .port_dir_i  (PORT_DIR_I),
        .port_read_o (PORT_READ_O),
        .pad_in_i    (PAD_IN_I),
        .pad_out_o   (PAD_OUT_O),
        .pad_oe_n_o  (PAD_OE_N_O),
        .analog_en_o (ANALOG_EN_O)
    );

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        q_nxt  = q_r;
        scr_wr = WR_I && (ADDR_I == SCR_ADDR);
        clk_wr = WR_I && (ADDR_I == CLK_ADDR);
        res_rd = RD_I && (ADDR_I == RES_ADDR);
        done   = 1'b0;
        idx    = ~q_r.cnt[2:0];
        // Wait mode has no effect here: only stop or the all-ones power-off code halts the engine
        start  = q_r.pend && tick && !STOP_I && (q_r.ch != CH_OFF);

        if (start) begin
            // A control write mid-conversion restarts it
            q_nxt.state = ST_CONV;
            q_nxt.cnt   = 4'h0;
            q_nxt.sar   = SAR_FIRST;
            q_nxt.pend  = 1'b0;
        end else if (q_r.state == ST_CONV && tick) begin
            if (q_r.cnt < TRIALS) begin
                // Keep trial bit only if input sits at or above it
                if (!CMP_HIGH_I) begin
                    q_nxt.sar[idx] = 1'b0;
                end
                if (idx != 3'h0) begin
                    q_nxt.sar[idx - 3'h1] = 1'b1;
                end
            end
            if (q_r.cnt == CNT_LAST) begin
                done         = 1'b1;
                q_nxt.result = q_r.sar;
                if (q_r.cont) begin
                    q_nxt.cnt = 4'h0;
                    q_nxt.sar = SAR_FIRST;
                end else begin
                    q_nxt.state = ST_IDLE;
                end
            end else begin
                q_nxt.cnt = q_r.cnt + 4'h1;
            end
        end

        // Stop aborts; the pending start brings it back afterwards
        if (STOP_I) begin
            if (q_r.state == ST_CONV) begin
                q_nxt.pend = 1'b1;
            end
            q_nxt.state = ST_IDLE;
            done        = 1'b0;
            q_nxt.result = q_r.result;
        end

        if (scr_wr) begin
            // Flag position of the write data is ignored
            q_nxt.ien  = WDATA_I[IEN_BIT];
            q_nxt.cont = WDATA_I[CONT_BIT];
            q_nxt.ch   = WDATA_I[4:0];
            q_nxt.pend = 1'b1;
            q_nxt.irq  = 1'b0;
        end
        if (clk_wr) begin
            q_nxt.div = WDATA_I[DIV_LSB +: 3];
        end

        if (q_nxt.ch == CH_OFF) begin
            q_nxt.state = ST_IDLE;
            q_nxt.pend  = 1'b0;
        end
        q_nxt.pwr = (q_nxt.ch != CH_OFF);

        if (res_rd) begin
            q_nxt.flag = 1'b0;
            q_nxt.irq  = 1'b0;
        end
        // Completion beats a same-cycle clear
        if (done) begin
            if (q_r.ien) begin
                q_nxt.irq = 1'b1;
            end else begin
                q_nxt.flag = 1'b1;
            end
        end
        if (q_nxt.ien) begin
            q_nxt.flag = 1'b0;
        end

        q_nxt.rdata = 8'h00;
        if (RD_I) begin
            unique case (ADDR_I)
                SCR_ADDR: q_nxt.rdata = {q_r.flag, q_r.ien, q_r.cont, q_r.ch};
                RES_ADDR: q_nxt.rdata = q_r.result;
                CLK_ADDR: q_nxt.rdata = {q_r.div, 5'h00};
                default:  q_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            q_r <= '{state: ST_IDLE, ch: CH_RESET, div: DIV_RESET,
                     result: RES_RESET, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign RDATA_O     = q_r.rdata;
    assign DAC_CODE_O  = q_r.sar;
    assign MUX_SEL_O   = q_r.ch;
    assign CONV_PWR_O  = q_r.pwr;
    assign CONV_BUSY_O = (q_r.state == ST_CONV);
    assign IRQ_O       = q_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    // Converter ticks since the current conversion began
    logic [4:0] tk_cnt;
    always_ff @(posedge CLK_I) begin
        if (RESET_I || start || done || q_r.state != ST_CONV) begin
            tk_cnt <= 5'h00;
        end else if (tick) begin
            tk_cnt <= tk_cnt + 5'h01;
        end
    end

    property p_len;
        done |-> (tk_cnt == 5'h0f);
    endproperty
    a_len : assert property (p_len)
        else $error("Conversion length is not sixteen ticks");

    property p_start;
        // A same-cycle power-off write legally cancels the start
        (start && !(scr_wr && WDATA_I[4:0] == CH_OFF))
            |=> (CONV_BUSY_O && q_r.cnt == 4'h0 && DAC_CODE_O == 8'h80);
    endproperty
    a_start : assert property (p_start)
        else $error("Conversion did not start on tick");

    property p_write_pends;
        (scr_wr && WDATA_I[4:0] != CH_OFF) |=> q_r.pend || CONV_BUSY_O;
    endproperty
    a_write_pends : assert property (p_write_pends)
        else $error("Control write lost its start");

    property p_result;
        (done && !scr_wr) |=> (q_r.result == $past(q_r.sar));
    endproperty
    a_result : assert property (p_result)
        else $error("Result not refreshed on completion");

    property p_cont;
        (done && q_r.cont && !STOP_I && !scr_wr) |=> CONV_BUSY_O && q_r.cnt == 4'h0;
    endproperty
    a_cont : assert property (p_cont)
        else $error("Continuous conversion did not follow");

    property p_single;
        (done && !q_r.cont && !start) |=> !CONV_BUSY_O;
    endproperty
    a_single : assert property (p_single)
        else $error("Single conversion did not stop");

    property p_flag;
        (done && !q_r.ien && !scr_wr) |=> (q_r.flag ##1 (q_r.flag || $past(res_rd) || q_r.ien));
    endproperty
    a_flag : assert property (p_flag)
        else $error("Done flag not set or dropped");

    property p_no_flag;
        q_r.ien |-> !q_r.flag;
    endproperty
    a_no_flag : assert property (p_no_flag)
        else $error("Flag set while interrupt enabled");

    property p_irq_clr;
        ((res_rd || scr_wr) && !done) |=> !IRQ_O;
    endproperty
    a_irq_clr : assert property (p_irq_clr)
        else $error("Interrupt not removed by access");

    property p_irq_set;
        (done && q_r.ien) |=> IRQ_O;
    endproperty
    a_irq_set : assert property (p_irq_set)
        else $error("Interrupt missing at completion");

    property p_off;
        (q_r.ch == CH_OFF) |-> (!CONV_BUSY_O && !CONV_PWR_O);
    endproperty
    a_off : assert property (p_off)
        else $error("Converter active while powered off");

    property p_stop;
        STOP_I |=> !CONV_BUSY_O;
    endproperty
    a_stop : assert property (p_stop)
        else $error("Conversion survived stop");

    c_single : cover property (done && !q_r.cont);
    c_cont   : cover property (done && q_r.cont ##1 CONV_BUSY_O);
    c_stop   : cover property (CONV_BUSY_O && STOP_I);
    c_irq    : cover property ($rose(IRQ_O));

endmodule : sad_sequencer

// ### tb/sad_analog_model.sv
`timescale 1ns/1ps
module sad_analog_model (
    // Converter side
    input  wire logic [7:0]      dac_i,
    input  wire logic [4:0]      sel_i,
    input  wire logic [3:0][7:0] level_i,
    output logic                 cmp_high_o,
    // Pads
    input  wire logic [3:0]      pad_out_i,
    input  wire logic [3:0]      pad_oe_n_i,
    input  wire logic [3:0]      ext_i,
    output logic [3:0]           pad_o
);
    logic [7:0] vin;

    always_comb begin
        if (sel_i[4:2] == 3'h0) begin
            vin = level_i[sel_i[1:0]];
        end else if (sel_i == 5'h1d) begin
            vin = 8'hff;
        end else if (sel_i == 5'h1e) begin
            vin = 8'h00;
        end else begin
            vin = 8'h5a;
        end
    end

    // Linear coding: trial bit kept while input is at or above it
    assign cmp_high_o = (vin >= dac_i);
    // Released pads follow the outside level, not the last driven one
    assign pad_o = (pad_oe_n_i & ext_i) | (~pad_oe_n_i & pad_out_i);
endmodule : sad_analog_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import sad_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stop = 1'b0, cmp;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, dac, v;
    logic [4:0] msel;
    logic [3:0] pdata = 4'h0, pdir = 4'h0, ext = 4'h0, pad, pread, pout, poen, aen;
    logic       pwr, busy, irq;
    logic [3:0][7:0] lvl = {8'hff, 8'h00, 8'h3c, 8'ha5};
    int         fail_count = 0, checked = 0, cycles = 0, n;

    always #2.5 clk = ~clk;

    sad_sequencer i_sad_sequencer (
        .CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .STOP_I(stop), .CMP_HIGH_I(cmp), .DAC_CODE_O(dac), .MUX_SEL_O(msel),
        .CONV_PWR_O(pwr), .CONV_BUSY_O(busy), .IRQ_O(irq), .PORT_DATA_I(pdata), .PORT_DIR_I(pdir),
        .PORT_READ_O(pread), .PAD_IN_I(pad), .PAD_OUT_O(pout), .PAD_OE_N_O(poen), .ANALOG_EN_O(aen));

    sad_analog_model i_sad_analog_model (
        .dac_i(dac), .sel_i(msel), .level_i(lvl), .cmp_high_o(cmp),
        .pad_out_i(pout), .pad_oe_n_i(poen), .ext_i(ext), .pad_o(pad));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Flag position of control writes always forced to zero here
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= (a == 8'h3c) ? {1'b0, d[6:0]} : d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Cycles from the taking edge until completion shows
    task automatic wait_done(input logic use_irq, output int cnt);
        logic seen_busy;
        seen_busy = 1'b0;
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
            if (busy === 1'b1) seen_busy = 1'b1;
        end while (!(use_irq ? irq === 1'b1 : (seen_busy && busy === 1'b0)) && cnt < 400);
        chk("completion_seen", 16'(cnt < 400), 16'h1);
    endtask : wait_done

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_reg(8'h3c, v); chk("ctrl_reset", v, 8'h1f);
        chk("pwr_reset", pwr, 1'b0);
        rd_reg(8'h3f, v); chk("div_reset", v, 8'h00);
        rd_reg(8'h3d, v); chk("unmapped_read", v, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_divide();
        int p;
        for (int d = 0; d < 5; d++) begin
            p = 1 << d;
            wr_reg(8'h3f, {d[2:0], 5'h00});
            wr_reg(8'h3c, 8'h00);
            wait_done(1'b0, n);
            chk("conv_cycles", 16'(n >= 16 * p + 1 && n <= 17 * p + 1), 16'h1);
            chk("dac_final", dac, 8'ha5);
            rd_reg(8'h3c, v); chk("flag_set", v, 8'h80);
            rd_reg(8'h3e, v); chk("result", v, 8'ha5);
            rd_reg(8'h3c, v); chk("flag_cleared", v, 8'h00);
            chk("single_stops", busy, 1'b0);
        end
        wr_reg(8'h3f, 8'h00);
        $display("divide test done");
    endtask : t_divide

    task automatic t_channels();
        logic [4:0] code [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e};
        logic [7:0] res  [6] = '{8'ha5, 8'h3c, 8'h00, 8'hff, 8'hff, 8'h00};
        logic [3:0] en   [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0};
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h3c, {3'h0, code[i]});
            wait_done(1'b0, n);
            chk("mux_sel", msel, code[i]);
            chk("analog_en", aen, en[i]);
            rd_reg(8'h3e, v); chk("chan_result", v, res[i]);
        end
        wr_reg(8'h3e, 8'h11);
        rd_reg(8'h3e, v); chk("result_read_only", v, 8'h00);
        $display("channel test done");
    endtask : t_channels

    task automatic t_irq();
        wr_reg(8'h3c, 8'h41);
        wait_done(1'b1, n);
        rd_reg(8'h3c, v); chk("flag_masked", v, 8'h41);
        rd_reg(8'h3e, v); chk("irq_result", v, 8'h3c);
        chk("irq_clr_read", irq, 1'b0);
        wr_reg(8'h3c, 8'h41);
        wait_done(1'b1, n);
        wr_reg(8'h3c, 8'h5f);
        #1;
        chk("irq_clr_write", irq, 1'b0);
        chk("power_off", pwr, 1'b0);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_cont();
        int m;
        wr_reg(8'h3c, 8'h60);
        wait_done(1'b1, n);
        // First result after power-up is thrown away
        rd_reg(8'h3e, v);
        m = 2;
        while (irq !== 1'b1 && m < 100) begin
            @(posedge clk);
            #1;
            m++;
        end
        chk("cont_spacing", 16'(m), 16'd16);
        rd_reg(8'h3e, v); chk("cont_result", v, 8'ha5);
        // Interrupted conversion's data is never read
        wr_reg(8'h3c, 8'h00);
        repeat (40) @(posedge clk);
        #1;
        chk("cont_ceased_irq", irq, 1'b0);
        chk("cont_ceased_busy", busy, 1'b0);
        $display("continuous test done");
    endtask : t_cont

    task automatic t_pins();
        @(posedge clk);
        pdir  <= 4'hd;
        pdata <= 4'hf;
        ext   <= 4'h2;
        wr_reg(8'h3c, 8'h01);
        repeat (6) @(posedge clk);
        #1;
        chk("sel_released", poen[1], 1'b1);
        chk("sel_read_dir0", pread[1], 1'b0);
        chk("other_driven", {poen[0], pout[0]}, 2'b01);
        @(posedge clk);
        pdir <= 4'hf;
        repeat (6) @(posedge clk);
        #1;
        chk("sel_still_released", poen[1], 1'b1);
        chk("sel_read_dir1", pread[1], 1'b1);
        wait_done(1'b0, n);
        rd_reg(8'h3e, v);
        // Unselected inputs pass the pad filter; selected one stays 0
        @(posedge clk);
        pdir <= 4'h0;
        ext  <= 4'h6;
        repeat (8) @(posedge clk);
        #1;
        chk("pad_read", pread, 4'h4);
        $display("pin test done");
    endtask : t_pins

    task automatic t_stop();
        wr_reg(8'h3f, 8'h20);
        wr_reg(8'h3c, 8'h00);
        repeat (8) @(posedge clk);
        stop <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("stop_aborts", busy, 1'b0);
        @(posedge clk);
        stop <= 1'b0;
        wait_done(1'b0, n);
        chk("stop_resume_time", 16'(n >= 33 && n <= 36), 16'h1);
        rd_reg(8'h3e, v); chk("stop_result", v, 8'ha5);
        $display("stop test done");
    endtask : t_stop

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_divide();
        t_channels();
        t_irq();
        t_cont();
        t_pins();
        t_stop();
        end_of_test();
    end
endmodule : tb
